// ==== src/fcs_pkg.sv ====
// shared constants and types of the flash status and interrupt block
package fcs_pkg;

   // register byte addresses
   localparam logic [31:0] FCS_STATUS_ADDR = 32'h4004_8000;
   localparam logic [31:0] FCS_IRQ_EN_ADDR = 32'h4004_8004;
   localparam logic [31:0] FCS_EVT_ADDR    = 32'h4004_8040;
   localparam logic [31:0] FCS_MASK_ADDR   = 32'h4004_8044;

   // flash_status fields
   localparam int unsigned FCS_ST_BUSY_BIT   = 0;
   localparam int unsigned FCS_ST_CLOSED_BIT = 1;
   localparam int unsigned FCS_ST_DONE_BIT   = 2;
   localparam int unsigned FCS_ST_HALF_BIT   = 3;
   localparam int unsigned FCS_ST_FAIL_LSB   = 4;
   localparam int unsigned FCS_ST_FAIL_MSB   = 5;

   // flash_irq_enable fields; event and mask registers share this layout
   localparam int unsigned FCS_EN_DONE_BIT = 0;
   localparam int unsigned FCS_EN_HALF_BIT = 1;
   localparam int unsigned FCS_EN_FAIL_BIT = 2;
   localparam int unsigned FCS_EN_W        = 3;

   // reset values
   localparam logic [2:0] FCS_IRQ_EN_RST = 3'h0;
   localparam logic [2:0] FCS_EVT_RST    = 3'h0;
   localparam logic [2:0] FCS_MASK_RST   = 3'h0;
   localparam logic [1:0] FCS_FAIL_RST   = 2'h0;

   // command fail codes
   localparam logic [1:0] FCS_FAIL_NONE   = 2'h0;
   localparam logic [1:0] FCS_FAIL_PROT   = 2'h1;
   localparam logic [1:0] FCS_FAIL_VERIFY = 2'h2;
   localparam logic [1:0] FCS_FAIL_ABORT  = 2'h3;

   // data widths
   localparam int unsigned FCS_FLASH_WORD_W = 72;
   localparam int unsigned FCS_SIG_W        = 32;

   // kind of command handed over by the command register
   typedef enum logic [1:0] {
      FCS_OP_OTHER,
      FCS_OP_SIGN,
      FCS_OP_WRITE,
      FCS_OP_ERASE
   } fcs_op_e;

endpackage

// ==== src/fcs_erase_verify.sv ====
// erase read-back checker: flags any word that is not all ones
`timescale 1ns/1ps
module fcs_erase_verify #(
   parameter int unsigned WORD_W = 72
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              clear,
   input  wire logic              word_valid,
   input  wire logic [WORD_W-1:0] word,
   output logic                   bad
);
   logic bad_q;
   logic cur_bad;

   assign cur_bad = word_valid && (word != {WORD_W{1'b1}});
   // includes the word arriving now so the last word counts too
   assign bad = bad_q | cur_bad;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bad_q <= 1'b0;
      end else if (clear) begin
         bad_q <= 1'b0;
      end else if (cur_bad) begin
         bad_q <= 1'b1;
      end
   end
endmodule

// ==== src/fcs_fail_latch.sv ====
// holds the first nonzero fail code until it is read
`timescale 1ns/1ps
module fcs_fail_latch
   import fcs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       fin,
   input  wire logic [1:0] code,
   input  wire logic       clear,
   output logic [1:0]      code_q
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code_q <= FCS_FAIL_RST;
      end else if (fin && code != FCS_FAIL_NONE && (code_q == FCS_FAIL_NONE || clear)) begin
         code_q <= code;
      end else if (clear) begin
         code_q <= FCS_FAIL_NONE;
      end
   end
endmodule

// ==== src/fcs_status_irq.sv ====
// flash controller status, interrupt enable and interrupt logic with APB slave
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module fcs_status_irq #(
   parameter int unsigned WORD_W = 72,
   parameter int unsigned SIG_W  = 32
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               cmd_start,
   input  wire fcs_pkg::fcs_op_e   cmd_op,
   input  wire logic               cmd_target_protected,
   input  wire logic               cmd_abort,
   input  wire logic               op_end,
   input  wire logic [SIG_W-1:0]   sig_computed,
   input  wire logic [SIG_W-1:0]   sig_stored,
   input  wire logic               verify_word_valid,
   input  wire logic [WORD_W-1:0]  verify_word,
   input  wire logic               verify_last,
   input  wire logic               keyhole_loaded,
   input  wire logic               half_write_done,
   input  wire logic               write_done,
   output logic                    cmd_ignore,
   output logic                    cmd_active,
   output logic                    verify_req,
   output logic                    irq
);
   import fcs_pkg::*;

   typedef enum logic [1:0] {
      FCS_IDLE,
      FCS_RUN,
      FCS_VERIFY
   } fcs_state_e;

   fcs_state_e st_q;
   fcs_state_e st_d;
   fcs_op_e    op_q;

   logic        fin;
   logic [1:0]  fin_code;
   logic        ignore_d;
   logic        verify_clear;
   logic        verify_bad;
   logic        wr_pend_q;

   logic        done_q;
   logic        half_q;
   logic        closed_q;
   logic [1:0]  fail_code_q;
   logic [2:0]  en_q;
   logic [2:0]  evt_q;
   logic [2:0]  evt_d;
   logic [2:0]  evt_set;
   logic [2:0]  evt_clr;
   logic [2:0]  mask_q;

   logic        setup;
   logic        hit;
   logic        rd_status;
   logic        wr_fire;
   logic [31:0] rdata;

   logic        cmd_ignore_q;
   logic        cmd_active_q;
   logic        verify_req_q;
   logic        irq_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;

   assign cmd_ignore = cmd_ignore_q;
   assign cmd_active = cmd_active_q;
   assign verify_req = verify_req_q;
   assign irq        = irq_q;
   assign prdata     = prdata_q;
   assign pready     = pready_q;
   assign pslverr    = pslverr_q;

   // ---------------------------------------------------------------
   // command sequencing and outcome
   // ---------------------------------------------------------------
   always_comb begin
      st_d         = st_q;
      fin          = 1'b0;
      fin_code     = FCS_FAIL_NONE;
      ignore_d     = 1'b0;
      verify_clear = 1'b0;
      unique case (st_q)
         FCS_IDLE: begin
            if (cmd_start) begin
               if (cmd_target_protected && cmd_op != FCS_OP_OTHER) begin
                  fin      = 1'b1;
                  fin_code = FCS_FAIL_PROT;
                  ignore_d = 1'b1;
               end else begin
                  st_d = FCS_RUN;
               end
            end else if (cmd_abort && wr_pend_q) begin
               fin      = 1'b1;
               fin_code = FCS_FAIL_ABORT;
            end else if (write_done && wr_pend_q) begin
               fin      = 1'b1;
               fin_code = FCS_FAIL_NONE;
            end
         end
         FCS_RUN: begin
            if (cmd_abort) begin
               fin      = 1'b1;
               fin_code = FCS_FAIL_ABORT;
               st_d     = FCS_IDLE;
            end else if (op_end) begin
               if (op_q == FCS_OP_ERASE) begin
                  verify_clear = 1'b1;
                  st_d         = FCS_VERIFY;
               end else begin
                  fin  = 1'b1;
                  st_d = FCS_IDLE;
                  if (op_q == FCS_OP_SIGN && sig_computed != sig_stored) begin
                     fin_code = FCS_FAIL_PROT;
                  end
               end
            end
         end
         FCS_VERIFY: begin
            if (cmd_abort) begin
               fin      = 1'b1;
               fin_code = FCS_FAIL_ABORT;
               st_d     = FCS_IDLE;
            end else if (verify_word_valid && verify_last) begin
               fin  = 1'b1;
               st_d = FCS_IDLE;
               if (verify_bad) begin
                  fin_code = FCS_FAIL_VERIFY;
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= FCS_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_q <= FCS_OP_OTHER;
      end else if (st_q == FCS_IDLE && cmd_start) begin
         op_q <= cmd_op;
      end
   end

   // keyhole write in flight, outside the command state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_pend_q <= 1'b0;
      end else if (keyhole_loaded) begin
         wr_pend_q <= 1'b1;
      end else if (write_done || cmd_abort) begin
         wr_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_active_q <= 1'b0;
         cmd_ignore_q <= 1'b0;
         verify_req_q <= 1'b0;
      end else begin
         cmd_active_q <= (st_d != FCS_IDLE);
         cmd_ignore_q <= ignore_d;
         verify_req_q <= (st_d == FCS_VERIFY);
      end
   end

   fcs_erase_verify #(
      .WORD_W (WORD_W)
   ) u_verify (
      .clk        (pclk),
      .rst_n      (presetn),
      .clear      (verify_clear),
      .word_valid (verify_word_valid && st_q == FCS_VERIFY),
      .word       (verify_word),
      .bad        (verify_bad)
   );

   fcs_fail_latch u_fail (
      .clk    (pclk),
      .rst_n  (presetn),
      .fin    (fin),
      .code   (fin_code),
      .clear  (rd_status),
      .code_q (fail_code_q)
   );

   // ---------------------------------------------------------------
   // status flags; a setting event beats a read clear
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 1'b0;
      end else if (fin) begin
         done_q <= 1'b1;
      end else if (rd_status) begin
         done_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_q <= 1'b0;
      end else if (half_write_done) begin
         half_q <= 1'b1;
      end else if (rd_status) begin
         half_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         closed_q <= 1'b0;
      end else if (keyhole_loaded) begin
         closed_q <= 1'b1;
      end else if (half_write_done) begin
         closed_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // interrupt enables, events and mask
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= FCS_IRQ_EN_RST;
      end else if (wr_fire && paddr == FCS_IRQ_EN_ADDR) begin
         en_q <= pwdata[FCS_EN_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= FCS_MASK_RST;
      end else if (wr_fire && paddr == FCS_MASK_ADDR) begin
         mask_q <= pwdata[FCS_EN_W-1:0];
      end
   end

   always_comb begin
      evt_set                  = 3'h0;
      evt_set[FCS_EN_DONE_BIT] = fin && en_q[FCS_EN_DONE_BIT];
      evt_set[FCS_EN_HALF_BIT] = half_write_done && en_q[FCS_EN_HALF_BIT];
      evt_set[FCS_EN_FAIL_BIT] = fin && fin_code != FCS_FAIL_NONE
                                 && en_q[FCS_EN_FAIL_BIT];
      evt_clr = 3'h0;
      if (wr_fire && paddr == FCS_EVT_ADDR) begin
         evt_clr = pwdata[FCS_EN_W-1:0];
      end
      if (rd_status) begin
         evt_clr = 3'h7;
      end
      evt_d = (evt_q & ~evt_clr) | evt_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_q <= FCS_EVT_RST;
         irq_q <= 1'b0;
      end else begin
         evt_q <= evt_d;
         irq_q <= |(evt_d & mask_q);
      end
   end

   // ---------------------------------------------------------------
   // APB slave: one wait-free access, read data captured at setup
   // ---------------------------------------------------------------
   assign setup     = psel && !penable;
   assign hit       = (paddr == FCS_STATUS_ADDR) || (paddr == FCS_IRQ_EN_ADDR)
                      || (paddr == FCS_EVT_ADDR) || (paddr == FCS_MASK_ADDR);
   assign rd_status = setup && !pwrite && paddr == FCS_STATUS_ADDR;
   assign wr_fire   = psel && penable && pready_q && pwrite && hit;

   always_comb begin
      rdata = 32'h0000_0000;
      unique case (paddr)
         FCS_STATUS_ADDR: begin
            rdata[FCS_ST_BUSY_BIT]                  = cmd_active_q;
            rdata[FCS_ST_CLOSED_BIT]                = closed_q;
            rdata[FCS_ST_DONE_BIT]                  = done_q;
            rdata[FCS_ST_HALF_BIT]                  = half_q;
            rdata[FCS_ST_FAIL_MSB:FCS_ST_FAIL_LSB] = fail_code_q;
         end
         FCS_IRQ_EN_ADDR: begin
            rdata[FCS_EN_DONE_BIT] = en_q[FCS_EN_DONE_BIT];
            rdata[FCS_EN_HALF_BIT] = 1'b0;
            rdata[FCS_EN_FAIL_BIT] = en_q[FCS_EN_FAIL_BIT];
         end
         FCS_EVT_ADDR: begin
            rdata[FCS_EN_W-1:0] = evt_q;
         end
         FCS_MASK_ADDR: begin
            rdata[FCS_EN_W-1:0] = mask_q;
         end
         default: begin
            rdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && !hit;
         prdata_q  <= (setup && !pwrite) ? rdata : 32'h0000_0000;
      end
   end

endmodule

// ==== dv/fcs_status_irq_props.sv ====
// concurrent checks on the ports of the flash status and interrupt block
`timescale 1ns/1ps
module fcs_status_irq_props
   import fcs_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       paddr,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              cmd_start,
   input wire fcs_pkg::fcs_op_e  cmd_op,
   input wire logic              cmd_target_protected,
   input wire logic              cmd_abort,
   input wire logic              op_end,
   input wire logic              verify_last,
   input wire logic              keyhole_loaded,
   input wire logic              half_write_done,
   input wire logic              write_done,
   input wire logic              cmd_ignore,
   input wire logic              cmd_active,
   input wire logic              irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic sts_rd;
   logic quiet;
   assign sts_rd = psel && !penable && !pwrite && (paddr == FCS_STATUS_ADDR);
   assign quiet  = !op_end && !cmd_abort && !verify_last && !write_done && !half_write_done
                   && !keyhole_loaded && !cmd_start;

   property p_busy_rise;
      cmd_start && !cmd_active && !cmd_abort && (!cmd_target_protected || cmd_op == FCS_OP_OTHER)
         |=> cmd_active;
   endproperty
   a_busy_rise: assert property (p_busy_rise)
      else $error("command did not turn active");
   property p_busy_hold;
      cmd_active && !op_end && !cmd_abort && !verify_last |=> cmd_active;
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("active flag dropped early");
   property p_protect;
      cmd_start && !cmd_active && cmd_target_protected && cmd_op != FCS_OP_OTHER
         |=> cmd_ignore && !cmd_active;
   endproperty
   a_protect: assert property (p_protect)
      else $error("protected command not refused");
   property p_ignore_pulse;
      cmd_ignore |=> !cmd_ignore;
   endproperty
   a_ignore_pulse: assert property (p_ignore_pulse)
      else $error("refusal pulse too long");
   property p_abort_end;
      cmd_active && cmd_abort |=> !cmd_active;
   endproperty
   a_abort_end: assert property (p_abort_end)
      else $error("abort did not end command");
   property p_en_read;
      psel && !penable && !pwrite && paddr == FCS_IRQ_EN_ADDR |=> pready && !prdata[1];
   endproperty
   a_en_read: assert property (p_en_read)
      else $error("half-done enable read back nonzero");
   property p_flags_rc;
      (sts_rd && quiet) ##1 quiet [*2] ##1 (sts_rd && quiet) |=> prdata[5:2] == 4'h0;
   endproperty
   a_flags_rc: assert property (p_flags_rc)
      else $error("read-clear flags survived a read");
   property p_closed;
      keyhole_loaded ##1 (sts_rd && !half_write_done) |=> prdata[FCS_ST_CLOSED_BIT];
   endproperty
   a_closed: assert property (p_closed)
      else $error("keyhole closed flag missing");
   property p_irq_hold;
      irq && !psel |=> irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt dropped without software action");
endmodule

bind fcs_status_irq fcs_status_irq_props u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .cmd_start(cmd_start), .cmd_op(cmd_op),
   .cmd_target_protected(cmd_target_protected), .cmd_abort(cmd_abort), .op_end(op_end),
   .verify_last(verify_last), .keyhole_loaded(keyhole_loaded),
   .half_write_done(half_write_done), .write_done(write_done), .cmd_ignore(cmd_ignore),
   .cmd_active(cmd_active), .irq(irq)
);

// ==== dv/flash_ctrl_status_irq_test.sv ====
// self-checking bench for the flash status and interrupt block
`timescale 1ns/1ps
module flash_ctrl_status_irq_test;
   import fcs_pkg::*;
   typedef struct packed {
      fcs_op_e    op;
      logic       pr;
      logic [1:0] md;
      logic [1:0] fail;
   } fcs_row_s;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic        prot    = 1'b0;
   logic [31:0] paddr   = 32'h0;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] sig_c   = 32'h0;
   logic [71:0] vword   = '1;
   logic [7:0]  ev      = 8'h00;
   fcs_op_e     op      = FCS_OP_OTHER;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic        cmd_ignore;
   logic        cmd_active;
   logic        verify_req;
   logic        irq;
   int          error_cnt = 0;
   int          tests_run = 0;
   // md: 0 clean, 1 signature mismatch, 2 bad erase word, 3 abort
   fcs_row_s    rows [9] = '{
      '{FCS_OP_OTHER, 1'h0, 2'h0, 2'h0}, '{FCS_OP_SIGN, 1'h0, 2'h0, 2'h0},
      '{FCS_OP_SIGN, 1'h0, 2'h1, 2'h1}, '{FCS_OP_WRITE, 1'h1, 2'h0, 2'h1},
      '{FCS_OP_ERASE, 1'h0, 2'h0, 2'h0}, '{FCS_OP_ERASE, 1'h0, 2'h2, 2'h2},
      '{FCS_OP_WRITE, 1'h0, 2'h3, 2'h3}, '{FCS_OP_ERASE, 1'h1, 2'h0, 2'h1},
      '{FCS_OP_SIGN, 1'h1, 2'h0, 2'h1}};

   always #2.5 pclk = ~pclk;

   fcs_status_irq u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmd_start(ev[0]), .cmd_op(op), .cmd_target_protected(prot), .cmd_abort(ev[1]),
      .op_end(ev[2]), .sig_computed(sig_c), .sig_stored(32'h0), .verify_word_valid(ev[3]),
      .verify_word(vword), .verify_last(ev[4]), .keyhole_loaded(ev[5]),
      .half_write_done(ev[6]), .write_done(ev[7]), .cmd_ignore(cmd_ignore),
      .cmd_active(cmd_active), .verify_req(verify_req), .irq(irq));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one cycle pulse on the selected event inputs
   task automatic fire(input logic [7:0] m);
      ev <= m;
      @(posedge pclk);
      ev <= 8'h00;
   endtask

   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // request held until the edge that samples pready high
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never reassigns psel in this step
      @(posedge pclk);
   endtask

   task automatic irq_is(input logic e);
      @(negedge pclk);
      chk({31'h0, irq}, {31'h0, e});
      @(posedge pclk);
   endtask

   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      report_and_stop;
   end

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, FCS_IRQ_EN_ADDR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, FCS_STATUS_ADDR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 32'h4004_8010, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, FCS_IRQ_EN_ADDR, 32'h7);
      apb(1'b0, FCS_IRQ_EN_ADDR, 32'h0);
      chk(rd, 32'h5);
      apb(1'b1, FCS_MASK_ADDR, 32'h7);
      for (int i = 0; i < 9; i++) begin
         op <= rows[i].op;
         prot <= rows[i].pr;
         sig_c <= (rows[i].md == 2'h1) ? 32'h1 : 32'h0;
         fire(8'h01);
         @(negedge pclk);
         chk({30'h0, cmd_ignore, cmd_active}, rows[i].pr ? 32'h2 : 32'h1);
         @(posedge pclk);
         if (!rows[i].pr) begin
            fire(rows[i].md == 2'h3 ? 8'h02 : 8'h04);
            if (rows[i].op == FCS_OP_ERASE && rows[i].md != 2'h3) begin
               @(negedge pclk);
               chk({31'h0, verify_req}, 32'h1);
               @(posedge pclk);
               vword <= (rows[i].md == 2'h2) ? 72'h0 : '1;
               fire(8'h08);
               @(posedge pclk);
               vword <= '1;
               fire(8'h18);
            end
         end
         repeat (2) @(posedge pclk);
         if (!rows[i].pr) begin
            apb(1'b0, FCS_EVT_ADDR, 32'h0);
            chk(rd & 32'h7, {29'h0, rows[i].fail != 2'h0, 2'h1});
            irq_is(1'b1);
         end
         apb(1'b0, FCS_STATUS_ADDR, 32'h0);
         chk(rd & 32'h31, {26'h0, rows[i].fail, 4'h0});
      end
      // two unread commands, then a protected start while busy that is dropped without a cmd_ignore pulse
      sig_c <= 32'h1;
      op <= FCS_OP_SIGN;
      prot <= 1'b0;
      fire(8'h01);
      @(posedge pclk);
      fire(8'h04);
      @(posedge pclk);
      op <= FCS_OP_WRITE;
      fire(8'h01);
      @(posedge pclk);
      prot <= 1'b1;
      fire(8'h01);
      @(negedge pclk);
      chk({30'h0, cmd_ignore, cmd_active}, 32'h1);
      @(posedge pclk);
      prot <= 1'b0;
      fire(8'h02);
      repeat (2) @(posedge pclk);
      apb(1'b0, FCS_STATUS_ADDR, 32'h0);
      chk(rd & 32'h35, 32'h14);
      apb(1'b0, FCS_STATUS_ADDR, 32'h0);
      chk(rd & 32'h3F, 32'h0);
      // keyhole write with half-done interrupt enabled
      fire(8'h20);
      apb(1'b0, FCS_STATUS_ADDR, 32'h0);
      chk(rd & 32'hA, 32'h2);
      apb(1'b0, FCS_STATUS_ADDR, 32'h0);
      chk(rd & 32'hA, 32'h2);
      irq_is(1'b0);
      fire(8'h40);
      @(posedge pclk);
      irq_is(1'b1);
      apb(1'b0, FCS_STATUS_ADDR, 32'h0);
      chk(rd & 32'h8, 32'h8);
      apb(1'b0, FCS_STATUS_ADDR, 32'h0);
      chk(rd & 32'h8, 32'h0);
      fire(8'h80);
      @(posedge pclk);
      irq_is(1'b1);
      apb(1'b1, FCS_EVT_ADDR, 32'h7);
      irq_is(1'b0);
      // half-done interrupt disabled
      apb(1'b1, FCS_IRQ_EN_ADDR, 32'h5);
      fire(8'h20);
      @(posedge pclk);
      fire(8'h40);
      repeat (2) @(posedge pclk);
      irq_is(1'b0);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, FCS_IRQ_EN_ADDR, 32'h0);
      chk(rd, 32'h0);
      report_and_stop;
   end
endmodule
